// ==== src/sram_port_pkg.sv ====
// shared constants and carrier types of the pipelined burst sram port
package sram_port_pkg;
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int BURST_LEN = 4;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CLK_TO_OUT_DELAY_PS = 2500;
  localparam int CLK_TO_OUT_DELAY_CYC =
    (CLK_TO_OUT_DELAY_PS / CLK_PERIOD_PS) < 1 ? 1
    : CLK_TO_OUT_DELAY_PS / CLK_PERIOD_PS;
  localparam logic [1:0] STEP_RESET = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [2:0] STRAP_SYNC_RESET = 3'h7;
  localparam logic MODE_RESET = 1'b1;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] COUNT_FULL = 2'h2;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;
  typedef logic [LANE_W-1:0] lane_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_n;
  } stage_t;

  typedef struct packed {
    logic [ADDR_W-1:0]       addr;
    logic [LANES-1:0]        lane_n;
    lane_t [LANES-1:0]       lanes;
  } wbeat_t;
endpackage : sram_port_pkg

// ==== src/pipelined_burst_sram_port.sv ====
// pipelined burst sram port: command decode, burst counter, data pipes
//
// Behaviour
// - clock qualifier high freezes all state except the strap synchronizer on that edge.
// - read starts on qualified fetch, all selects on, write enable high.
// - qualified fetch edge captures the presented address.
// - read data leaves the output register at the edge after the command.
// - data driven only while the asynchronous drive enable is low.
// - a new command is accepted right after a read, no wait cycles.
// - deselect at a command edge tristates outputs after the next edge.
// - burst counter wraps after four accesses per loaded address and keeps stepping.
// - burst order strap low is linear, high is interleaved.
// - bursts change only the two low address bits and wrap.
// - step level on a qualified edge advances burst, ignoring selects.
// - read or write direction is latched at burst start and held.
// - write starts on qualified edge, all selects on, write enable low.
// - edge after a write command forces data and parity to tristate.
// - write data is sampled on the second edge after the command.
// - only lanes with their select asserted are written.
// - each parity bit follows its byte lane select.
// - drivers stay off the first clock after leaving deselect.
`timescale 1ns/1ps
module pipelined_burst_sram_port
(
  input  wire logic                                clock,
  input  wire logic                                reset,
  input  wire logic                                clk_qualify_n,
  input  wire logic                                chip_sel_1_n,
  input  wire logic                                chip_sel_2,
  input  wire logic                                chip_sel_3_n,
  input  wire logic                                step_or_fetch,
  input  wire logic                                write_en_n,
  input  wire logic [sram_port_pkg::LANES-1:0]     byte_lane_sel_n,
  input  wire logic                                out_drive_n,
  input  wire logic                                burst_interleave,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]    addr,
  input  wire logic [sram_port_pkg::DATA_W-1:0]    dq_in,
  output logic      [sram_port_pkg::DATA_W-1:0]    dq_out,
  output logic                                     dq_oe_n,
  input  wire logic [sram_port_pkg::LANES-1:0]     parity_in,
  output logic      [sram_port_pkg::LANES-1:0]     parity_out,
  output logic                                     parity_oe_n
);
  import sram_port_pkg::*;

  localparam int RD_LAT = CLK_TO_OUT_DELAY_CYC;

  logic                    en;
  logic                    sel;
  logic                    active_q;
  op_t                     dir_q;
  logic [1:0]              base_q;
  logic [1:0]              step_q;
  logic [1:0]              step_nx;
  logic [ADDR_W-3:0]       hi_q;
  logic [1:0]              low_nx;
  stage_t                  cmd_d;
  stage_t                  st1_q;
  stage_t                  st2_q;
  logic [2:0]              strap_q;
  logic                    mode_q;
  logic                    drive_q;
  lane_t [LANES-1:0]       out_d;
  lane_t [LANES-1:0]       out_q;
  wbeat_t                  buf_q [BUF_DEPTH];
  logic                    wr_ptr_q;
  logic                    rd_ptr_q;
  logic [1:0]              count_q;
  logic                    full;
  logic                    push;
  logic                    rd_fetch;
  logic                    drain_valid;
  logic                    drain_ready;
  logic                    drain;
  logic                    push_ready;
  wbeat_t                  live;
  wbeat_t                  older;
  wbeat_t                  newer;

  assign en = ~clk_qualify_n;
  assign sel = ~chip_sel_1_n & chip_sel_2 & ~chip_sel_3_n;
  assign step_nx = step_q + STEP_ONE;

  // strap is asynchronous; accept a level once two late stages agree
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      strap_q <= STRAP_SYNC_RESET;
      mode_q  <= MODE_RESET;
    end
    else
    begin
      strap_q <= {strap_q[1:0], burst_interleave};
      if (strap_q[1] == strap_q[2])
        mode_q <= strap_q[2];
    end
  end

  // only the two low bits move, so the group wraps by itself
  assign low_nx = mode_q ? base_q ^ step_nx : base_q + step_nx;

  always_comb
  begin
    cmd_d.op     = OP_IDLE;
    cmd_d.addr   = addr;
    cmd_d.lane_n = byte_lane_sel_n;
    if (!step_or_fetch)
    begin
      if (sel)
        cmd_d.op = write_en_n ? OP_READ : OP_WRITE;
    end
    else if (active_q)
    begin
      cmd_d.op   = dir_q;
      cmd_d.addr = {hi_q, low_nx};
    end
  end

  // burst state; a step with no live burst stays deselected
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      active_q <= 1'b0;
      dir_q    <= OP_IDLE;
      base_q   <= STEP_RESET;
      step_q   <= STEP_RESET;
      hi_q     <= '0;
    end
    else if (en)
    begin
      if (!step_or_fetch)
      begin
        active_q <= sel;
        base_q   <= addr[1:0];
        hi_q     <= addr[ADDR_W-1:2];
        step_q   <= STEP_RESET;
        dir_q    <= write_en_n ? OP_READ : OP_WRITE;
      end
      else if (active_q)
        step_q <= step_nx;
    end
  end

  // every command edge shifts the pipe, so back-to-back needs no wait
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st1_q <= '{op: OP_IDLE, addr: '0, lane_n: '1};
      st2_q <= '{op: OP_IDLE, addr: '0, lane_n: '1};
    end
    else if (en)
    begin
      st1_q <= cmd_d;
      st2_q <= st1_q;
    end
  end

  // write beat buffer: two entries, drained into the array
  assign full        = count_q == COUNT_FULL;
  assign push        = en && st2_q.op == OP_WRITE;
  assign rd_fetch    = en && st1_q.op == OP_READ;
  assign drain_valid = count_q != COUNT_RESET;
  // reads own the array port; a full buffer takes it back
  assign drain_ready = en && (!rd_fetch || full);
  assign drain       = drain_valid && drain_ready;
  assign push_ready  = !full || drain;
  assign older       = buf_q[rd_ptr_q];
  assign newer       = buf_q[~rd_ptr_q];

  always_comb
  begin
    live.addr   = st2_q.addr;
    live.lane_n = st2_q.lane_n;
    for (int i = 0; i < LANES; i++)
      live.lanes[i] = {parity_in[i], dq_in[i*BYTE_W +: BYTE_W]};
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= COUNT_RESET;
    end
    else
    begin
      if (push && push_ready)
      begin
        buf_q[wr_ptr_q] <= live;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (drain)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push && push_ready} - {1'b0, drain};
    end
  end

  // per lane storage; later writes override earlier ones on a read
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    lane_t mem [2**ADDR_W];
    lane_t v;

    always_ff @(posedge clock)
    begin
      if (drain && !older.lane_n[g])
        mem[older.addr] <= older.lanes[g];
    end

    always_comb
    begin
      v = mem[st1_q.addr];
      if (drain_valid && older.addr == st1_q.addr && !older.lane_n[g])
        v = older.lanes[g];
      if (full && newer.addr == st1_q.addr && !newer.lane_n[g])
        v = newer.lanes[g];
      if (push && live.addr == st1_q.addr && !live.lane_n[g])
        v = live.lanes[g];
      out_d[g] = v;
    end

    assign dq_out[g*BYTE_W +: BYTE_W] = out_q[g][BYTE_W-1:0];
    assign parity_out[g] = out_q[g][BYTE_W];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      drive_q <= 1'b0;
      out_q   <= '0;
    end
    else if (en)
    begin
      // write and deselect slots and the first slot out of deselect
      drive_q <= st1_q.op == OP_READ;
      if (rd_fetch)
        out_q <= out_d;
    end
  end

  // the drive enable is asynchronous, so it gates the flop directly
  assign dq_oe_n     = ~drive_q | out_drive_n;
  assign parity_oe_n = ~drive_q | out_drive_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_rd_cmd;
    en && sel && !step_or_fetch && write_en_n;
  endsequence

  sequence s_wr_cmd;
    en && sel && !step_or_fetch && !write_en_n;
  endsequence

  sequence s_desel_cmd;
    en && !sel && !step_or_fetch;
  endsequence

  property p_freeze;
    clk_qualify_n |=> $stable(st1_q) && $stable(step_q) && $stable(out_q)
      && $stable(drive_q) && $stable(active_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved on an unqualified edge");

  property p_read_start;
    s_rd_cmd |=> st1_q.op == OP_READ && st1_q.addr == $past(addr);
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read command not captured");

  property p_addr_load;
    en && !step_or_fetch |=> base_q == $past(addr[1:0]) && step_q == 2'h0;
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("fetch edge did not load the address");

  property p_read_out;
    s_rd_cmd ##RD_LAT en |=> drive_q;
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read data not presented after command");

  property p_oe_gate;
    (out_drive_n || !drive_q) |-> dq_oe_n && parity_oe_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("drivers on without enable");

  property p_desel;
    s_desel_cmd ##1 en |=> !drive_q && dq_oe_n;
  endproperty
  a_desel: assert property (p_desel)
    else $error("outputs active after deselect");

  property p_write_tri;
    s_wr_cmd ##1 en |=> dq_oe_n && parity_oe_n;
  endproperty
  a_write_tri: assert property (p_write_tri)
    else $error("drivers on in write data slot");

  property p_write_sample;
    s_wr_cmd ##1 en ##1 en |-> push && push_ready;
  endproperty
  a_write_sample: assert property (p_write_sample)
    else $error("write beat not taken on second edge");

  property p_step;
    en && step_or_fetch && active_q |=>
      step_q == $past(step_q) + 2'h1 && st1_q.op == $past(dir_q);
  endproperty
  a_step: assert property (p_step)
    else $error("burst step lost or direction changed");

  property p_order;
    en && step_or_fetch && active_q |=> st1_q.addr[1:0] == (mode_q
      ? (base_q ^ step_q) : (base_q + step_q))
      && st1_q.addr[ADDR_W-1:2] == hi_q;
  endproperty
  a_order: assert property (p_order)
    else $error("burst address order wrong");

  property p_cont_desel;
    en && step_or_fetch && !active_q |=> st1_q.op == OP_IDLE && !active_q;
  endproperty
  a_cont_desel: assert property (p_cont_desel)
    else $error("step without burst left deselect");

endmodule : pipelined_burst_sram_port

// ==== tb/host_lanes.sv ====
// host side of the shared data lanes, with the wire resolved between parties
`timescale 1ns/1ps
module host_lanes
(
  input  wire logic                             clock,
  input  wire logic                             drive_en,
  input  wire logic [sram_port_pkg::DATA_W-1:0] drive_dq,
  input  wire logic [sram_port_pkg::LANES-1:0]  drive_par,
  input  wire logic [sram_port_pkg::DATA_W-1:0] dq_out,
  input  wire logic                             dq_oe_n,
  input  wire logic [sram_port_pkg::LANES-1:0]  parity_out,
  input  wire logic                             parity_oe_n,
  output logic      [sram_port_pkg::DATA_W-1:0] dq_in,
  output logic      [sram_port_pkg::LANES-1:0]  parity_in
);
  import sram_port_pkg::*;
  logic [DATA_W-1:0] dq_last_q = '0;
  logic [LANES-1:0]  par_last_q = '0;
  // no pull on the lanes, so a released wire toggles instead of holding
  always_comb
  begin
    if (!dq_oe_n)
      dq_in = dq_out;
    else if (drive_en)
      dq_in = drive_dq;
    else
      dq_in = ~dq_last_q;
    if (!parity_oe_n)
      parity_in = parity_out;
    else if (drive_en)
      parity_in = drive_par;
    else
      parity_in = ~par_last_q;
  end
  always_ff @(posedge clock)
  begin
    dq_last_q <= dq_in;
    par_last_q <= parity_in;
  end
endmodule : host_lanes

// ==== tb/pipelined_burst_sram_port_tb.sv ====
// random bursts, stalls, lane masks and deselects against a shadow memory
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
  import sram_port_pkg::*;
  localparam int W = DATA_W + LANES;
  logic              clock, reset, clk_qualify_n, step_or_fetch;
  logic              chip_sel_1_n, chip_sel_2, chip_sel_3_n, write_en_n;
  logic [LANES-1:0]  byte_lane_sel_n, parity_in, parity_out, p1m, p2m;
  logic              out_drive_n, burst_interleave, dq_oe_n, parity_oe_n;
  logic [ADDR_W-1:0] addr, p1a, p2a, bb;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic              host_en, fresh;
  logic [W-1:0]      host_val;
  logic [W-1:0]      shadow [logic [ADDR_W-1:0]];
  logic [1:0]        p1k, p2k, bk, bn;
  int                fails, check_count;

  pipelined_burst_sram_port pipelined_burst_sram_port_inst
  (
    .clock(clock), .reset(reset), .clk_qualify_n(clk_qualify_n),
    .chip_sel_1_n(chip_sel_1_n), .chip_sel_2(chip_sel_2),
    .chip_sel_3_n(chip_sel_3_n), .step_or_fetch(step_or_fetch),
    .write_en_n(write_en_n), .byte_lane_sel_n(byte_lane_sel_n),
    .out_drive_n(out_drive_n), .burst_interleave(burst_interleave),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .parity_in(parity_in), .parity_out(parity_out),
    .parity_oe_n(parity_oe_n)
  );

  host_lanes host_lanes_inst
  (
    .clock(clock), .drive_en(host_en), .drive_dq(host_val[DATA_W-1:0]),
    .drive_par(host_val[W-1:DATA_W]), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .parity_out(parity_out), .parity_oe_n(parity_oe_n), .dq_in(dq_in),
    .parity_in(parity_in)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out();
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] b,
                                              input logic [1:0] k);
    logic [1:0] low;
    low = burst_interleave ? (b[1:0] ^ k) : (b[1:0] + k);
    return {b[ADDR_W-1:2], low};
  endfunction : baddr

  // one edge: check what the last edge produced, then drive the next one
  task automatic issue(input logic [1:0] kind, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] m, input logic stl);
    logic [W-1:0] t;
    logic [2:0]   s;
    @(negedge clock);
    if (p2k == 2'h1)
    begin
      check(W'({dq_oe_n, parity_oe_n}), W'({2{out_drive_n}}));
      check({parity_out, dq_out}, shadow[p2a]);
    end
    else
      check(W'({dq_oe_n, parity_oe_n}), W'(2'h3));
    host_en = (p2k == 2'h2);
    if (host_en && fresh)
    begin
      host_val = W'({$urandom, $urandom});
      t = shadow.exists(p2a) ? shadow[p2a] : 'x;
      for (int g = 0; g < LANES; g++)
        if (!p2m[g])
        begin
          t[BYTE_W*g+:BYTE_W] = host_val[BYTE_W*g+:BYTE_W];
          t[DATA_W+g] = host_val[DATA_W+g];
        end
      shadow[p2a] = t;
    end
    s = 3'($urandom);
    if (kind == 2'h0 && s == 3'h2)
      s = 3'h5;
    if (kind == 2'h1 || kind == 2'h2)
      s = 3'h2;
    {chip_sel_1_n, chip_sel_2, chip_sel_3_n} = s;
    clk_qualify_n = stl;
    step_or_fetch = (kind == 2'h3);
    write_en_n = (kind == 2'h2) ? 1'b0 : (kind == 2'h1) ? 1'b1 : 1'($urandom);
    addr = (kind == 2'h3) ? ADDR_W'($urandom) : a;
    byte_lane_sel_n = m;
    out_drive_n = ($urandom % 4 == 0);
    fresh = !stl;
    if (!stl)
    begin
      p2k = p1k;
      p2a = p1a;
      p2m = p1m;
      p1k = kind;
      p1a = a;
      p1m = m;
      if (kind == 2'h3)
      begin
        p1k = bk;
        bn = bn + 2'h1;
        p1a = baddr(bb, bn);
      end
      else
      begin
        bk = kind;
        bb = a;
        bn = 2'h0;
      end
    end
  endtask : issue

  task automatic burst(input logic [1:0] kind, input logic [ADDR_W-1:0] a,
                       input logic full);
    logic [LANES-1:0] m;
    m = full ? '0 : LANES'($urandom);
    issue(kind, a, m, 1'b0);
    for (int k = 1; k < BURST_LEN; k++)
    begin
      if ($urandom % 3 == 0)
        issue(2'($urandom), ADDR_W'($urandom), m, 1'b1);
      m = full ? '0 : LANES'($urandom);
      issue(2'h3, a, m, 1'b0);
    end
  endtask : burst

  initial
  begin
    repeat (100000) @(posedge clock);
    fails++;
    close_out();
  end

  initial
  begin
    logic [ADDR_W-1:0] a;
    fails = 0;
    check_count = 0;
    {reset, chip_sel_1_n, byte_lane_sel_n} = '1;
    {clk_qualify_n, chip_sel_2, chip_sel_3_n, step_or_fetch} = '0;
    {write_en_n, out_drive_n, burst_interleave, addr, host_en} = '0;
    {host_val, p1k, p2k, bk, bn, p1a, p2a, p1m, p2m, bb, fresh} = '0;
    void'($urandom(93650));
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    for (int md = 0; md < 2; md++)
    begin
      burst_interleave = md[0];
      repeat (5) issue(2'h0, '0, '1, 1'b0);
      for (int i = 0; i < 12; i++)
      begin
        a = ADDR_W'($urandom);
        burst(2'h2, a, 1'b1);
        burst(2'h2, a, 1'b0);
        burst(2'h1, a, 1'b0);
        issue(2'h0, a, '1, 1'b0);
        issue(2'h3, a, '1, 1'b0);
        issue(2'h1, a, '1, 1'b0);
      end
    end
    repeat (3) issue(2'h0, '0, '1, 1'b0);
    close_out();
  end
endmodule : pipelined_burst_sram_port_tb
